/* File: rtl/plh_pkg.sv */
// Shared constants and the phase comparator of the lock detector.
package plh_pkg;
	// ************************************************************
	// Register map and fields.
	// ************************************************************
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_LOCK_CNT = 8'h04;
	localparam logic [7:0] OFS_WINDOW   = 8'h08;
	localparam logic [7:0] OFS_MANUAL_DAC_VALUE  = 8'h0c;
	localparam logic [7:0] OFS_STATUS   = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	localparam int CTRL_MODE_LO  = 0;
	localparam int CTRL_MODE_HI  = 1;
	localparam int CTRL_LLDIS    = 2;
	localparam int CTRL_TRACK    = 3;
	localparam int CTRL_MANEN    = 4;
	localparam int ST_LOCK_BIT   = 0;
	localparam int ST_HOLD_BIT   = 1;
	localparam int IRQ_W         = 4;
	localparam int IRQ_LOCK_GAIN = 0;
	localparam int IRQ_LOCK_LOSS = 1;
	localparam int IRQ_HOLD_IN   = 2;
	localparam int IRQ_HOLD_OUT  = 3;
	// ************************************************************
	// Widths and reset values.
	// ************************************************************
	localparam int CNT_W = 14;
	localparam int WIN_W = 8;
	localparam int DAC_W = 10;
	localparam logic [1:0]       HOLD_MODE_ON  = 2'h2;
	localparam logic [1:0]       MODE_RST      = 2'h0;
	localparam logic [CNT_W-1:0] LOCK_CNT_RST  = 14'h2710;
	localparam logic [WIN_W-1:0] WINDOW_RST    = 8'h04;
	localparam logic [DAC_W-1:0] MANUAL_DAC_VALUE_RST   = 10'h200;
	localparam logic [1:0]       RESP_OKAY     = 2'h0;
	localparam logic [1:0]       RESP_SLVERR   = 2'h2;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SYNC_STAGES   = 3;
	typedef enum logic [1:0] {ST_LOCKING, ST_LOCKED, ST_HOLDOVER} plh_state_t;
endpackage

`timescale 1ns/1ns
`default_nettype none
module plh_phase_cmp #(
	parameter int ERR_W = plh_pkg::WIN_W + 1
) (
	// Clock and reset.
	input  wire logic                      mclk,
	input  wire logic                      rst_b,
	// Edges seen on reference and feedback.
	input  wire logic                      ref_rise,
	input  wire logic                      fb_rise,
	input  wire logic [plh_pkg::WIN_W-1:0] phase_window_size,
	// One result per comparison.
	output logic                           cmp_valid,
	output logic                           cmp_in_window
);
	import plh_pkg::*;
	logic             armed;
	logic             ref_first;
	logic [ERR_W-1:0] err;

	// A comparison opens on whichever edge comes first and closes on the
	// other one. A repeated edge of the same input, or an error count
	// that saturates, closes it as out of window so a dead input cannot
	// leave the detector looking locked.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			armed         <= 1'b0;
			ref_first     <= 1'b0;
			err           <= '0;
			cmp_valid     <= 1'b0;
			cmp_in_window <= 1'b0;
		end else begin
			cmp_valid <= 1'b0;
			if (!armed) begin
				if (ref_rise && fb_rise) begin
					cmp_valid     <= 1'b1;
					cmp_in_window <= 1'b1;
				end else if (ref_rise || fb_rise) begin
					armed     <= 1'b1;
					ref_first <= ref_rise;
					err       <= ERR_W'(1);
				end
			end else if ((ref_first && fb_rise) || (!ref_first && ref_rise)) begin
				cmp_valid     <= 1'b1;
				cmp_in_window <= err <= {1'b0, phase_window_size};
				armed         <= (ref_rise && fb_rise);
				err           <= ERR_W'(1);
			end else if ((ref_first ? ref_rise : fb_rise) || (&err)) begin
				cmp_valid     <= 1'b1;
				cmp_in_window <= 1'b0;
				armed         <= 1'b0;
				err           <= '0;
			end else begin
				err <= err + ERR_W'(1);
			end
		end
	end
endmodule
`default_nettype wire

/* File: rtl/plh_top.sv */
// Lock detector and holdover controller with its AXI4-Lite registers.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module plh_top (
	// Clock and reset.
	input  wire logic                      mclk,
	input  wire logic                      rst_b,
	// Reference and feedback at phase-detector rate, reference valid.
	input  wire logic                      ref_clk_in,
	input  wire logic                      fb_clk_in,
	input  wire logic                      ref_present,
	// Tuning code from the running loop, same clock.
	input  wire logic [plh_pkg::DAC_W-1:0] loop_dac,
	// Tuning code out, lock and holdover status.
	output logic [plh_pkg::DAC_W-1:0]      tune_dac,
	output logic                           lock_indicator,
	output logic                           holdover_active,
	output logic                           irq,
	// AXI4-Lite slave.
	input  wire logic [7:0]                s_awaddr,
	input  wire logic                      s_awvalid,
	output logic                           s_awready,
	input  wire logic [31:0]               s_wdata,
	input  wire logic [3:0]                s_wstrb,
	input  wire logic                      s_wvalid,
	output logic                           s_wready,
	output logic [1:0]                     s_bresp,
	output logic                           s_bvalid,
	input  wire logic                      s_bready,
	input  wire logic [7:0]                s_araddr,
	input  wire logic                      s_arvalid,
	output logic                           s_arready,
	output logic [31:0]                    s_rdata,
	output logic [1:0]                     s_rresp,
	output logic                           s_rvalid,
	input  wire logic                      s_rready
);
	import plh_pkg::*;

	// ************************************************************
	// Pin synchronisers.
	// ************************************************************
	logic [2:0] pin_in;
	logic [2:0] pin_q;
	logic [2:0] pin_q_d;
	assign pin_in = {ref_present, fb_clk_in, ref_clk_in};
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_sync
			logic [SYNC_STAGES-1:0] sh;
			// A change counts only once stages two and three agree.
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					sh        <= '0;
					pin_q[g]   <= 1'b0;
					pin_q_d[g] <= 1'b0;
				end else begin
					sh <= {sh[SYNC_STAGES-2:0], pin_in[g]};
					if (sh[1] == sh[2])
						pin_q[g] <= sh[2];
					pin_q_d[g] <= pin_q[g];
				end
			end
		end
	endgenerate
	logic ref_rise;
	logic fb_rise;
	logic ref_ok;
	assign ref_rise = pin_q[0] & ~pin_q_d[0];
	assign fb_rise  = pin_q[1] & ~pin_q_d[1];
	assign ref_ok   = pin_q[2];

	// ************************************************************
	// Control registers.
	// ************************************************************
	logic [1:0]       holdover_mode;
	logic             lock_loss_holdover_disable;
	logic             track_enable;
	logic             manual_dac_enable;
	logic [CNT_W-1:0] lock_count_threshold;
	logic [WIN_W-1:0] phase_window_size;
	logic [DAC_W-1:0] manual_dac_value;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_event;
	logic             wr_do;
	logic [7:0]       aw_addr;
	logic [31:0]      w_data;
	logic             aw_held;
	logic             w_held;
	assign wr_do = aw_held && w_held && !s_bvalid;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			holdover_mode              <= MODE_RST;
			lock_loss_holdover_disable <= 1'b0;
			track_enable               <= 1'b0;
			manual_dac_enable          <= 1'b0;
			lock_count_threshold       <= LOCK_CNT_RST;
			phase_window_size          <= WINDOW_RST;
			manual_dac_value           <= MANUAL_DAC_VALUE_RST;
			irq_mask                   <= '0;
		end else if (wr_do) begin
			case (aw_addr)
				OFS_CTRL: begin
					holdover_mode              <= w_data[CTRL_MODE_HI:CTRL_MODE_LO];
					lock_loss_holdover_disable <= w_data[CTRL_LLDIS];
					track_enable               <= w_data[CTRL_TRACK];
					manual_dac_enable          <= w_data[CTRL_MANEN];
				end
				OFS_LOCK_CNT: lock_count_threshold <= w_data[CNT_W-1:0];
				OFS_WINDOW:   phase_window_size    <= w_data[WIN_W-1:0];
				OFS_MANUAL_DAC_VALUE:  manual_dac_value     <= w_data[DAC_W-1:0];
				OFS_IRQ_MASK: irq_mask             <= w_data[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			irq_stat <= '0;
		else if (wr_do && aw_addr == OFS_IRQ_STAT)
			irq_stat <= (irq_stat & ~w_data[IRQ_W-1:0]) | irq_event;
		else
			irq_stat <= irq_stat | irq_event;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= |(irq_stat & irq_mask);
	end

	// ************************************************************
	// Lock detector.
	// ************************************************************
	logic             cmp_valid;
	logic             cmp_in_window;
	logic [CNT_W-1:0] lock_cnt;
	logic [CNT_W:0]   cnt_plus;
	logic             cnt_hit;
	plh_state_t       st;
	logic             relock;

	plh_phase_cmp #(.ERR_W(WIN_W + 1)) u_cmp (
		.mclk              (mclk),
		.rst_b             (rst_b),
		.ref_rise          (ref_rise),
		.fb_rise           (fb_rise),
		.phase_window_size (phase_window_size),
		.cmp_valid         (cmp_valid),
		.cmp_in_window     (cmp_in_window)
	);

	assign cnt_plus = {1'b0, lock_cnt} + (CNT_W+1)'(1);
	// Lock time is threshold comparisons at the comparison rate.
	assign cnt_hit  = cmp_valid && cmp_in_window
	                  && cnt_plus >= {1'b0, lock_count_threshold};
	assign relock   = (st == ST_HOLDOVER) && (ref_ok
	                  || holdover_mode != HOLD_MODE_ON);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lock_cnt       <= '0;
			lock_indicator <= 1'b0;
		end else if (relock || (cmp_valid && !cmp_in_window)) begin
			lock_cnt       <= '0;
			lock_indicator <= 1'b0;
		end else if (cmp_valid) begin
			if (!(&lock_cnt))
				lock_cnt <= cnt_plus[CNT_W-1:0];
			if (cnt_hit)
				lock_indicator <= 1'b1;
		end
	end

	// ************************************************************
	// Holdover control.
	// ************************************************************
	plh_state_t next_st;
	logic       lock_lost;
	assign lock_lost = cmp_valid && !cmp_in_window;

	always_comb begin
		next_st = st;
		case (st)
			ST_LOCKING:
				if (cnt_hit)
					next_st = ST_LOCKED;
			ST_LOCKED:
				// Only a loss in mode two with detection armed holds.
				if (lock_lost)
					next_st = (holdover_mode == HOLD_MODE_ON
					           && !lock_loss_holdover_disable)
					          ? ST_HOLDOVER : ST_LOCKING;
			ST_HOLDOVER:
				if (relock)
					next_st = ST_LOCKING;
			default: next_st = ST_LOCKING;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			st <= ST_LOCKING;
		else
			st <= next_st;
	end

	assign irq_event[IRQ_LOCK_GAIN] = cnt_hit && !lock_indicator;
	assign irq_event[IRQ_LOCK_LOSS] = lock_lost && lock_indicator;
	assign irq_event[IRQ_HOLD_IN]   = st != ST_HOLDOVER && next_st == ST_HOLDOVER;
	assign irq_event[IRQ_HOLD_OUT]  = relock;

	// Tracked value follows the loop only while locked and enabled.
	logic [DAC_W-1:0] tracked;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			tracked <= MANUAL_DAC_VALUE_RST;
		else if (track_enable && st == ST_LOCKED)
			tracked <= loop_dac;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tune_dac        <= MANUAL_DAC_VALUE_RST;
			holdover_active <= 1'b0;
		end else begin
			holdover_active <= st == ST_HOLDOVER;
			if (st != ST_HOLDOVER)
				tune_dac <= loop_dac;
			else if (manual_dac_enable)
				tune_dac <= manual_dac_value;
			else
				tune_dac <= tracked;
		end
	end

	// ************************************************************
	// AXI4-Lite slave.
	// ************************************************************
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			aw_addr   <= '0;
			w_data    <= '0;
			s_bvalid  <= 1'b0;
			s_bresp   <= RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_held   <= 1'b1;
				s_awready <= 1'b0;
				aw_addr   <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_held   <= 1'b1;
				s_wready <= 1'b0;
				// Registers are narrower than a byte lane group only in
				// width, so a cleared strobe zeroes its lane.
				for (int i = 0; i < 4; i++)
					w_data[i*8 +: 8] <= s_wstrb[i] ? s_wdata[i*8 +: 8] : 8'h00;
			end
			if (wr_do) begin
				s_bvalid <= 1'b1;
				s_bresp  <= (aw_addr <= OFS_IRQ_MASK && aw_addr[1:0] == 2'h0
				             && aw_addr != OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid  <= 1'b0;
				aw_held   <= 1'b0;
				w_held    <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= '0;
			s_rresp   <= RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			s_rresp   <= RESP_OKAY;
			s_rdata   <= '0;
			case (s_araddr)
				OFS_CTRL: begin
					s_rdata[CTRL_MODE_HI:CTRL_MODE_LO] <= holdover_mode;
					s_rdata[CTRL_LLDIS] <= lock_loss_holdover_disable;
					s_rdata[CTRL_TRACK] <= track_enable;
					s_rdata[CTRL_MANEN] <= manual_dac_enable;
				end
				OFS_LOCK_CNT: s_rdata[CNT_W-1:0] <= lock_count_threshold;
				OFS_WINDOW:   s_rdata[WIN_W-1:0] <= phase_window_size;
				OFS_MANUAL_DAC_VALUE:  s_rdata[DAC_W-1:0] <= manual_dac_value;
				OFS_STATUS: begin
					s_rdata[ST_LOCK_BIT] <= lock_indicator;
					s_rdata[ST_HOLD_BIT] <= holdover_active;
				end
				OFS_IRQ_STAT: s_rdata[IRQ_W-1:0] <= irq_stat;
				OFS_IRQ_MASK: s_rdata[IRQ_W-1:0] <= irq_mask;
				default:      s_rresp <= RESP_SLVERR;
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid  <= 1'b0;
			s_arready <= 1'b1;
		end
	end

	// ************************************************************
	// Assertions.
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	AST_LOCK_RISE: assert property (cnt_hit && !relock |=> lock_indicator)
		else $error("lock not raised after count reached");
	AST_LOCK_NEEDS_COUNT: assert property (
		!lock_indicator ##1 lock_indicator |-> $past(cnt_hit))
		else $error("lock raised without full count");
	AST_LOCK_DROP: assert property (lock_lost |=> !lock_indicator)
		else $error("lock held after out-of-window comparison");
	AST_CNT_CLEAR: assert property (lock_lost |=> lock_cnt == '0)
		else $error("count not cleared on miss");
	AST_HOLD_ENTER: assert property (
		st == ST_LOCKED && lock_lost && holdover_mode == HOLD_MODE_ON
		&& !lock_loss_holdover_disable |=> ##1 holdover_active)
		else $error("holdover not entered on lock loss");
	AST_HOLD_MODE: assert property (
		st == ST_HOLDOVER |-> $past(holdover_mode) == HOLD_MODE_ON)
		else $error("holdover outside mode two");
	AST_HOLD_EXIT: assert property (
		st == ST_HOLDOVER && ref_ok |=> st == ST_LOCKING && lock_cnt == '0
		##1 !holdover_active)
		else $error("holdover not left with valid reference");
	AST_NO_TRACK: assert property (!track_enable |=> $stable(tracked))
		else $error("tracking while disabled");
	AST_MANUAL_DAC_VALUE: assert property (
		st == ST_HOLDOVER && manual_dac_enable
		|=> tune_dac == $past(manual_dac_value))
		else $error("holdover tuning not from manual value");
	AST_IRQ_LEVEL: assert property (
		|(irq_stat & irq_mask) |=> irq)
		else $error("interrupt not raised");

	COV_LOCK:     cover property (!lock_indicator ##1 lock_indicator);
	COV_HOLD_IN:  cover property (st == ST_LOCKED ##1 st == ST_HOLDOVER);
	COV_HOLD_OUT: cover property (st == ST_HOLDOVER ##1 st == ST_LOCKING);
	COV_W1C_RACE: cover property (wr_do && aw_addr == OFS_IRQ_STAT
	                              && |irq_event);
endmodule
`default_nettype wire

/* File: dv/plh_ref_model.sv */
// Reference and feedback clock source with a ramping loop tuning code.
`timescale 1ns/1ns
`default_nettype none
module plh_ref_model (
	// Clock and reset.
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Control from the bench.
	input  wire logic       run,
	input  wire logic       valid,
	input  wire logic [2:0] off,
	// Towards the block, and the period count to the bench.
	output logic            ref_clk_in,
	output logic            fb_clk_in,
	output logic            ref_present,
	output logic [9:0]      loop_dac,
	output logic [3:0]      cnt
);
	// A period is sixteen cycles, so edges of one input stay far apart.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 4'h0;
		end else if (run) begin
			cnt <= cnt + 4'h1;
		end
	end
	// Both clocks stand low while stopped, as a lost reference would.
	assign ref_clk_in  = run & ~cnt[3];
	assign fb_clk_in   = run & ((cnt - {1'b0, off}) < 4'h8);
	assign ref_present = valid;
	assign loop_dac    = 10'h300 + {6'h00, cnt};
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the lock detector and holdover controller.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import plh_pkg::*;
	// ************************************************************
	// Signals.
	// ************************************************************
	logic        mclk;
	logic        rst_b;
	logic        run;
	logic        valid;
	logic [2:0]  off;
	logic        ref_clk_in;
	logic        fb_clk_in;
	logic        ref_present;
	logic [9:0]  loop_dac;
	logic [3:0]  cnt;
	logic [9:0]  tune_dac;
	logic        lock_indicator;
	logic        holdover_active;
	logic        irq;
	logic [7:0]  s_awaddr;
	logic        s_awvalid;
	logic        s_awready;
	logic [31:0] s_wdata;
	logic [3:0]  s_wstrb;
	logic        s_wvalid;
	logic        s_wready;
	logic [1:0]  s_bresp;
	logic        s_bvalid;
	logic        s_bready;
	logic [7:0]  s_araddr;
	logic        s_arvalid;
	logic        s_arready;
	logic [31:0] s_rdata;
	logic [1:0]  s_rresp;
	logic        s_rvalid;
	logic        s_rready;
	int          err_count = 0;
	int          checks_done = 0;
	// Control words swept below; only the last three may hold over, and
	// the last one tracks the loop so holdover reuses its captured code.
	localparam logic [4:0] CTL [7] = '{5'h10, 5'h11, 5'h13, 5'h16, 5'h02,
		5'h12, 5'h0a};
	localparam logic [6:0] HOLD    = 7'b1110000;
	// Tuning code expected after each sweep step. The tracked code is the
	// loop code in the cycle the lost comparison is seen, count twelve.
	localparam logic [9:0] TUNE [7] = '{10'h30e, 10'h30e, 10'h30e, 10'h30e,
		10'h200, 10'h155, 10'h30c};

	plh_top dut (
		.mclk(mclk), .rst_b(rst_b), .ref_clk_in(ref_clk_in),
		.fb_clk_in(fb_clk_in), .ref_present(ref_present),
		.loop_dac(loop_dac), .tune_dac(tune_dac),
		.lock_indicator(lock_indicator), .holdover_active(holdover_active),
		.irq(irq), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
		.s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
		.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready)
	);
	plh_ref_model u_ref (
		.mclk(mclk), .rst_b(rst_b), .run(run), .valid(valid), .off(off),
		.ref_clk_in(ref_clk_in), .fb_clk_in(fb_clk_in),
		.ref_present(ref_present), .loop_dac(loop_dac), .cnt(cnt)
	);

	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	// ************************************************************
	// Shared tasks.
	// ************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, want);
		end
	endtask

	task automatic give_verdict;
		if (err_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Ready channels are held high, so the answer is taken where it is seen.
	task automatic wchk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge mclk);
			if (!aw && s_awready === 1'b1) begin
				aw = 1'b1;
				s_awvalid <= 1'b0;
			end
			if (!w && s_wready === 1'b1) begin
				w = 1'b1;
				s_wvalid <= 1'b0;
			end
		end
		while (s_bvalid !== 1'b1) @(posedge mclk);
		chk(s_bresp, er);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		do @(posedge mclk); while (s_arready !== 1'b1);
		s_arvalid <= 1'b0;
		while (s_rvalid !== 1'b1) @(posedge mclk);
		chk(s_rdata, d);
		chk(s_rresp, er);
	endtask

	// One reference period with the given feedback lag, judged at its end.
	task automatic per(input logic [2:0] o, input logic v, input logic lk);
		while (cnt !== 4'hf) @(posedge mclk);
		off <= o;
		valid <= v;
		repeat (16) @(posedge mclk);
		chk(lock_indicator, lk);
	endtask

	// ************************************************************
	// Scenarios.
	// ************************************************************
	// Outputs are judged while reset still holds them, then reset is let go.
	task automatic t_reset;
		chk(tune_dac, 10'h200);
		chk({lock_indicator, holdover_active, irq}, 3'h0);
		rst_b <= 1'b1;
		@(posedge mclk);
		rchk(OFS_CTRL, 32'h0, RESP_OKAY);
		rchk(OFS_LOCK_CNT, 32'h2710, RESP_OKAY);
		s_wstrb <= 4'h1;
		wchk(OFS_LOCK_CNT, 32'h1234, RESP_OKAY);
		s_wstrb <= 4'hf;
		rchk(OFS_LOCK_CNT, 32'h34, RESP_OKAY);
		rchk(OFS_WINDOW, 32'h4, RESP_OKAY);
		rchk(OFS_MANUAL_DAC_VALUE, 32'h200, RESP_OKAY);
		rchk(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		wchk(OFS_STATUS, 32'h3, RESP_SLVERR);
		rchk(OFS_STATUS, 32'h0, RESP_OKAY);
		rchk(8'h1c, 32'h0, RESP_SLVERR);
	endtask

	task automatic t_lock;
		wchk(OFS_LOCK_CNT, 32'h3, RESP_OKAY);
		wchk(OFS_MANUAL_DAC_VALUE, 32'h155, RESP_OKAY);
		wchk(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
		run <= 1'b1;
		valid <= 1'b1;
		per(3'h4, 1'b1, 1'b0);
		per(3'h4, 1'b1, 1'b0);
		per(3'h6, 1'b1, 1'b0);
		per(3'h4, 1'b1, 1'b0);
		per(3'h4, 1'b1, 1'b0);
		per(3'h4, 1'b1, 1'b1);
		chk(irq, 1'b1);
		chk(tune_dac, 10'h30e);
		rchk(OFS_STATUS, 32'h1, RESP_OKAY);
		per(3'h5, 1'b1, 1'b0);
		wchk(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0);
		wchk(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
		rchk(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
	endtask

	task automatic t_hold;
		for (int i = 0; i < 7; i++) begin
			wchk(OFS_CTRL, {27'h0, CTL[i]}, RESP_OKAY);
			per(3'h7, 1'b1, 1'b0);
			chk(holdover_active, 1'b0);
			per(3'h4, 1'b1, 1'b0);
			per(3'h4, 1'b1, 1'b0);
			per(3'h4, 1'b1, 1'b1);
			per(3'h7, 1'b0, 1'b0);
			per(3'h7, 1'b0, 1'b0);
			chk(holdover_active, HOLD[i]);
			chk(tune_dac, TUNE[i]);
		end
	endtask

	task automatic t_irq;
		run <= 1'b0;
		rchk(OFS_IRQ_STAT, 32'hf, RESP_OKAY);
		chk(irq, 1'b0);
		wchk(OFS_IRQ_MASK, 32'h4, RESP_OKAY);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b1);
		wchk(OFS_IRQ_STAT, 32'h4, RESP_OKAY);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0);
		rchk(OFS_IRQ_STAT, 32'hb, RESP_OKAY);
	endtask

	// ************************************************************
	// Sequence and watchdog.
	// ************************************************************
	initial begin
		rst_b = 1'b0;
		run = 1'b0;
		valid = 1'b0;
		off = 3'h7;
		s_awaddr = 8'h00;
		s_awvalid = 1'b0;
		s_wdata = 32'h0;
		s_wstrb = 4'hf;
		s_wvalid = 1'b0;
		s_bready = 1'b1;
		s_araddr = 8'h00;
		s_arvalid = 1'b0;
		s_rready = 1'b1;
		repeat (10) @(posedge mclk);
		t_reset;
		t_lock;
		t_hold;
		t_irq;
		give_verdict;
	end

	// The whole run needs roughly a thousand cycles; this leaves ample margin.
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		give_verdict;
	end
endmodule
`default_nettype wire
